// [hw/dcs_pkg.sv]
// Constants shared by the data/command and standard-speed timing block
package dcs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // Control one register
  localparam logic [7:0] ADDR_TARGET = 8'h04; // Target address
  localparam logic [7:0] ADDR_OWN    = 8'h08; // Own slave address
  localparam logic [7:0] ADDR_DATA   = 8'h10; // Data/command
  localparam logic [7:0] ADDR_SHIGH  = 8'h14; // Std SCL high count
  localparam logic [7:0] ADDR_SLOW   = 8'h18; // Std SCL low count
  localparam logic [7:0] ADDR_MASK   = 8'h30; // Event mask
  localparam logic [7:0] ADDR_STAT   = 8'h34; // Raw event status
  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT   = 0;  // Interface enable
  localparam int CTRL_MST_BIT  = 1;  // Master operation
  localparam int CMD_BIT       = 8;  // Read/write select
  localparam int STOP_BIT      = 9;  // Stop after entry
  localparam int TAR_STA_BIT   = 10; // Start byte select
  localparam int TAR_BCAST_BIT = 11; // Broadcast enable
  localparam int EV_RX_BIT     = 2;  // Byte received
  localparam int EV_TXE_BIT    = 4;  // Entry consumed
  localparam int EV_RREQ_BIT   = 5;  // Read request
  localparam int EV_ABORT_BIT  = 6;  // Transmit abort
  localparam int EV_STOP_BIT   = 9;  // Stop seen
  // ==========================================================
  // Widths, reset values and minimum counts
  localparam int CNT_W = 14;
  localparam int EV_W  = 10;
  localparam logic [CNT_W-1:0] SHIGH_RST = 14'h0190;
  localparam logic [CNT_W-1:0] SLOW_RST  = 14'h01D6;
  localparam logic [CNT_W-1:0] SHIGH_MIN = 14'h0006;
  localparam logic [CNT_W-1:0] SLOW_MIN  = 14'h0008;
  localparam logic [12:0]      TAR_RST   = 13'h1055;
  localparam logic [6:0]       OWN_RST   = 7'h55;
  localparam logic [7:0]       BCAST_ADR = 8'h00;
  localparam logic [3:0]       ACK_IDX   = 4'h8;
endpackage

// [hw/dcs_sync.sv]
// Two-flop synchroniser for the bus pin inputs
`timescale 1ns/1ps
module dcs_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta; // First stage, read only by second

  // ==========================================================
  // Both stages reset to the idle (released) bus level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [hw/dcs_data_cmd_timing.sv]
// Data/command port, standard SCL timing and byte engine of the controller
`timescale 1ns/1ps
// Overview of operation
// - Low byte sends data, reads last received
// - Select bit sets direction only as master
// - Select 0 writes, select 1 reads
// - Slave receiver ignores select; slave sends on 0
// - Read after broadcast raises transmit abort
// - Read entry on read request raises abort
// - Stop bit ends transfer after entry, as master only
// - 14-bit high count, reset 0x190, times high
// - 14-bit low count, reset 0x1D6, times low
// - Period counts writable only while disabled
// - High count below 6 stored as 6
// - Low count below 8 stored as 8
module dcs_data_cmd_timing
  import dcs_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // Interrupt
  output logic             irq,
  // Bus clock pin
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  // Bus data pin
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);
  // ==========================================================
  // Types
  typedef enum {MST_IDLE, MST_START, MST_BIT, MST_HOLD, MST_STOP} dcs_mst_t;
  typedef enum {SLV_IDLE, SLV_ADDR, SLV_RX, SLV_WAIT, SLV_TX} dcs_slv_t;

  // Raise a written count to its minimum
  function automatic logic [CNT_W-1:0] clampMin(input logic [CNT_W-1:0] v,
                                                input logic [CNT_W-1:0] m);
    clampMin = (v < m) ? m : v;
  endfunction

  // ==========================================================
  // Register state
  logic [1:0]       ctrl, next_ctrl;       // Enable and master mode
  logic [12:0]      tar, next_tar;         // Target address register
  logic [6:0]       own, next_own;         // Own slave address
  logic [CNT_W-1:0] sHigh, next_sHigh;     // Std high period count
  logic [CNT_W-1:0] sLow, next_sLow;       // Std low period count
  logic [EV_W-1:0]  mask, next_mask;       // Event mask
  logic [EV_W-1:0]  status, next_status;   // Sticky raw events
  logic [31:0]      next_regRdData;        // Read data
  logic             next_irq;              // Interrupt level

  // Engine state
  dcs_mst_t    mState, next_mState;        // Master sequencer
  dcs_slv_t    sState, next_sState;        // Slave sequencer
  logic [1:0]  step, next_step;            // Start/stop sub-step
  logic        phHigh, next_phHigh;        // Clock high phase
  logic [CNT_W-1:0] tmr, next_tmr;         // Phase timer
  logic [3:0]  bitCnt, next_bitCnt;        // Bit within byte
  logic [7:0]  shift, next_shift;          // Byte shifter
  logic        isAddr, next_isAddr;        // Address byte in flight
  logic        isRead, next_isRead;        // Current direction
  logic        ackOk, next_ackOk;          // Slave saw master ack
  logic [7:0]  rxData, next_rxData;        // Last byte received
  logic        entValid, next_entValid;    // Queued entry present
  logic [7:0]  entData, next_entData;      // Entry data byte
  logic        entCmd, next_entCmd;        // Entry read/write select
  logic        entStop, next_entStop;      // Entry stop control
  logic        sdaLow, next_sdaLow;        // Pull data low
  logic        sclLow, next_sclLow;        // Pull clock low
  logic        sclP, next_sclP;            // Previous clock sample
  logic        sdaP, next_sdaP;            // Previous data sample
  logic [EV_W-1:0] ev;                     // Event pulses this cycle

  // Synchronised pins and bus conditions
  logic        sclS;
  logic        sdaS;
  logic        enabled;
  logic        rise;
  logic        fall;
  logic        startC;
  logic        stopC;
  logic        tDone;
  logic        bcast;
  logic [7:0]  addrByte;
  logic        wantLow;

  // ==========================================================
  // Pin synchroniser
  dcs_sync #(.W(2)) uSync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     ({sclIn, sdaIn}),
    .dout    ({sclS, sdaS})
  );

  assign enabled  = ctrl[CTRL_EN_BIT];
  assign rise     = sclS & ~sclP;
  assign fall     = ~sclS & sclP;
  assign startC   = sclS & sclP & sdaP & ~sdaS;
  assign stopC    = sclS & sclP & ~sdaP & sdaS;
  assign tDone    = (tmr == '0);
  assign bcast    = tar[TAR_BCAST_BIT] & ~tar[TAR_STA_BIT];
  assign addrByte = bcast ? BCAST_ADR : {tar[6:0], entCmd};
  // Master drives ack low on a read byte unless it is the last
  assign wantLow  = (bitCnt == ACK_IDX) ? (isRead & ~isAddr & ~entStop)
                                        : ~shift[7];

  // ==========================================================
  // Register file: next values
  always_comb begin
    next_ctrl      = ctrl;
    next_tar       = tar;
    next_own       = own;
    next_sHigh     = sHigh;
    next_sLow      = sLow;
    next_mask      = mask;
    next_status    = status;
    next_regRdData = 32'h0000_0000;
    // Writes: decode by offset
    if (regWr) begin
      if (regAddr == ADDR_CTRL) begin
        next_ctrl = regWrData[1:0];
      end else if (regAddr == ADDR_TARGET) begin
        next_tar = regWrData[12:0];
      end else if (regAddr == ADDR_OWN) begin
        next_own = regWrData[6:0];
      end else if (regAddr == ADDR_SHIGH && !enabled) begin
        next_sHigh = clampMin(regWrData[CNT_W-1:0], SHIGH_MIN);
      end else if (regAddr == ADDR_SLOW && !enabled) begin
        next_sLow = clampMin(regWrData[CNT_W-1:0], SLOW_MIN);
      end else if (regAddr == ADDR_MASK) begin
        next_mask = regWrData[EV_W-1:0];
      end else if (regAddr == ADDR_STAT) begin
        next_status = status & ~regWrData[EV_W-1:0];
      end
    end
    // New events win over a same-cycle clear
    next_status = next_status | ev;
    // Reads: unused bits and unmapped offsets return zero
    if (regRd) begin
      if (regAddr == ADDR_CTRL) begin
        next_regRdData = {30'h0, ctrl};
      end else if (regAddr == ADDR_TARGET) begin
        next_regRdData = {19'h0, tar};
      end else if (regAddr == ADDR_OWN) begin
        next_regRdData = {25'h0, own};
      end else if (regAddr == ADDR_DATA) begin
        next_regRdData = {24'h0, rxData};
      end else if (regAddr == ADDR_SHIGH) begin
        next_regRdData = {18'h0, sHigh};
      end else if (regAddr == ADDR_SLOW) begin
        next_regRdData = {18'h0, sLow};
      end else if (regAddr == ADDR_MASK) begin
        next_regRdData = {22'h0, mask};
      end else if (regAddr == ADDR_STAT) begin
        next_regRdData = {22'h0, status};
      end
    end
    next_irq = |(next_status & next_mask);
  end

  // Register file: storage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl      <= 2'h0;
      tar       <= TAR_RST;
      own       <= OWN_RST;
      sHigh     <= SHIGH_RST;
      sLow      <= SLOW_RST;
      mask      <= '0;
      status    <= '0;
      regRdData <= 32'h0000_0000;
      irq       <= 1'b0;
      sclOut    <= 1'b0;
      sdaOut    <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      tar       <= next_tar;
      own       <= next_own;
      sHigh     <= next_sHigh;
      sLow      <= next_sLow;
      mask      <= next_mask;
      status    <= next_status;
      regRdData <= next_regRdData;
      irq       <= next_irq;
      sclOut    <= 1'b0; // Open drain: only ever pulls low
      sdaOut    <= 1'b0;
    end
  end

  // ==========================================================
  // Byte engine: next values
  always_comb begin
    next_mState   = mState;
    next_sState   = sState;
    next_step     = step;
    next_phHigh   = phHigh;
    next_tmr      = tDone ? tmr : tmr - 14'h0001;
    next_bitCnt   = bitCnt;
    next_shift    = shift;
    next_isAddr   = isAddr;
    next_isRead   = isRead;
    next_ackOk    = ackOk;
    next_rxData   = rxData;
    next_entValid = entValid;
    next_entData  = entData;
    next_entCmd   = entCmd;
    next_entStop  = entStop;
    next_sdaLow   = sdaLow;
    next_sclLow   = sclLow;
    next_sclP     = sclS;
    next_sdaP     = sdaS;
    ev            = '0;
    // Queue one entry from the data/command port
    if (regWr && regAddr == ADDR_DATA && enabled && !entValid) begin
      next_entValid = 1'b1;
      next_entData  = regWrData[7:0];
      next_entCmd   = regWrData[CMD_BIT];
      next_entStop  = regWrData[STOP_BIT];
    end
    if (!enabled) begin
      // Disabled: release the bus, idle both sequencers and drop the queued entry
      next_mState   = MST_IDLE;
      next_sState   = SLV_IDLE;
      next_entValid = 1'b0;
      next_sdaLow   = 1'b0;
      next_sclLow   = 1'b0;
    end else if (ctrl[CTRL_MST_BIT]) begin
      // ---------------- Master operation ----------------
      case (mState)
        MST_IDLE: begin
          next_sclLow = 1'b0;
          next_sdaLow = 1'b0;
          if (entValid && bcast && entCmd) begin
            next_entValid    = 1'b0;
            ev[EV_ABORT_BIT] = 1'b1;
          end else if (entValid) begin
            next_isRead = entCmd;
            next_mState = MST_START;
            next_step   = 2'd1;
            next_tmr    = sHigh - 14'h0001;
          end
        end
        MST_HOLD: begin
          // Clock held low while waiting for the next entry
          if (entValid && bcast && entCmd) begin
            next_entValid    = 1'b0;
            ev[EV_ABORT_BIT] = 1'b1;
          end else if (entValid && entCmd == isRead) begin
            next_mState = MST_BIT; // Same direction: next data byte
            next_isAddr = 1'b0;
            next_shift  = entCmd ? 8'hFF : entData;
            next_bitCnt = 4'h0;
            next_phHigh = 1'b0;
            next_tmr    = sLow - 14'h0001;
          end else if (entValid) begin
            next_isRead = entCmd; // Direction change: repeated start
            next_mState = MST_START;
            next_step   = 2'd0;
            next_tmr    = sLow - 14'h0001;
          end
        end
        MST_START: begin
          if (step == 2'd0) begin
            next_sdaLow = 1'b0;
            if (tDone) begin
              next_sclLow = 1'b0;
              next_step   = 2'd1;
              next_tmr    = sHigh - 14'h0001;
            end
          end else if (step == 2'd1) begin
            if (!sclS) begin
              next_tmr = tmr; // Wait for a stretched clock
            end else if (tDone) begin
              next_sdaLow = 1'b1; // Start condition
              next_step   = 2'd2;
              next_tmr    = sHigh - 14'h0001;
            end
          end else if (tDone) begin
            next_mState = MST_BIT;
            next_isAddr = 1'b1;
            next_shift  = addrByte;
            next_bitCnt = 4'h0;
            next_phHigh = 1'b0;
            next_sclLow = 1'b1;
            next_tmr    = sLow - 14'h0001;
          end
        end
        MST_BIT: begin
          if (!phHigh) begin
            next_sdaLow = wantLow;
            if (tDone) begin
              next_phHigh = 1'b1;
              next_sclLow = 1'b0;
              next_tmr    = sHigh - 14'h0001;
            end
          end else if (!sclS) begin
            next_tmr = tmr;
          end else if (tDone) begin
            next_phHigh = 1'b0;
            next_sclLow = 1'b1;
            next_tmr    = sLow - 14'h0001;
            if (bitCnt != ACK_IDX) begin
              next_shift  = {shift[6:0], sdaS};
              next_bitCnt = bitCnt + 4'h1;
            end else if (isAddr && sdaS) begin
              next_entValid    = 1'b0; // Address not acknowledged
              ev[EV_ABORT_BIT] = 1'b1;
              next_mState      = MST_STOP;
              next_step        = 2'd0;
            end else if (isAddr) begin
              next_isAddr = 1'b0;
              next_shift  = isRead ? 8'hFF : entData;
              next_bitCnt = 4'h0;
            end else begin
              next_entValid  = 1'b0;
              ev[EV_TXE_BIT] = 1'b1;
              if (isRead) begin
                next_rxData   = shift;
                ev[EV_RX_BIT] = 1'b1;
              end
              if (!isRead && sdaS) begin
                ev[EV_ABORT_BIT] = 1'b1;
                next_mState      = MST_STOP;
                next_step        = 2'd0;
              end else if (entStop) begin
                next_mState = MST_STOP;
                next_step   = 2'd0;
              end else begin
                next_mState = MST_HOLD;
              end
            end
          end
        end
        default: begin // MST_STOP
          if (step == 2'd0) begin
            next_sdaLow = 1'b1;
            if (tDone) begin
              next_sclLow = 1'b0;
              next_step   = 2'd1;
              next_tmr    = sHigh - 14'h0001;
            end
          end else if (step == 2'd1) begin
            if (!sclS) begin
              next_tmr = tmr;
            end else if (tDone) begin
              next_sdaLow = 1'b0; // Stop condition
              next_step   = 2'd2;
              next_tmr    = sHigh - 14'h0001;
            end
          end else if (tDone) begin
            next_mState     = MST_IDLE;
            ev[EV_STOP_BIT] = 1'b1;
          end
        end
      endcase
    end else begin
      // ---------------- Slave operation ----------------
      case (sState)
        SLV_ADDR: begin
          if (rise && bitCnt < ACK_IDX) begin
            next_shift  = {shift[6:0], sdaS};
            next_bitCnt = bitCnt + 4'h1;
          end else if (fall && bitCnt == ACK_IDX) begin
            if (shift[7:1] == own) begin
              next_sdaLow = 1'b1;
              next_isRead = shift[0];
              next_bitCnt = 4'h9;
            end else begin
              next_sState = SLV_IDLE;
            end
          end else if (fall && bitCnt == 4'h9) begin
            next_sdaLow = 1'b0;
            next_bitCnt = 4'h0;
            if (isRead) begin
              next_sState       = SLV_WAIT;
              next_sclLow       = 1'b1;
              ev[EV_RREQ_BIT]   = 1'b1;
            end else begin
              next_sState = SLV_RX;
            end
          end
        end
        SLV_RX: begin
          // Queued entries are left untouched while receiving
          if (rise && bitCnt < ACK_IDX) begin
            next_shift  = {shift[6:0], sdaS};
            next_bitCnt = bitCnt + 4'h1;
          end else if (fall && bitCnt == ACK_IDX) begin
            next_sdaLow   = 1'b1;
            next_rxData   = shift;
            ev[EV_RX_BIT] = 1'b1;
            next_bitCnt   = 4'h9;
          end else if (fall && bitCnt == 4'h9) begin
            next_sdaLow = 1'b0;
            next_bitCnt = 4'h0;
          end
        end
        SLV_WAIT: begin
          // Clock stretched until software supplies a byte
          if (entValid && entCmd) begin
            next_entValid    = 1'b0;
            ev[EV_ABORT_BIT] = 1'b1;
          end else if (entValid) begin
            next_entValid  = 1'b0;
            ev[EV_TXE_BIT] = 1'b1;
            next_shift     = entData;
            next_sdaLow    = ~entData[7];
            next_sclLow    = 1'b0;
            next_bitCnt    = 4'h0;
            next_sState    = SLV_TX;
          end
        end
        SLV_TX: begin
          if (rise && bitCnt < ACK_IDX) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (rise && bitCnt == ACK_IDX) begin
            next_ackOk  = ~sdaS;
            next_bitCnt = 4'h9;
          end else if (fall && bitCnt < ACK_IDX) begin
            next_sdaLow = ~shift[3'(4'h7 - bitCnt)];
          end else if (fall && bitCnt == ACK_IDX) begin
            next_sdaLow = 1'b0; // Release for master ack
          end else if (fall && bitCnt == 4'h9) begin
            if (ackOk) begin
              next_sState     = SLV_WAIT;
              next_sclLow     = 1'b1;
              ev[EV_RREQ_BIT] = 1'b1;
            end else begin
              next_sState = SLV_IDLE;
            end
          end
        end
        default: begin // SLV_IDLE
          next_sdaLow = 1'b0;
          next_sclLow = 1'b0;
        end
      endcase
      // Bus conditions override any slave state
      if (startC) begin
        next_sState = SLV_ADDR;
        next_bitCnt = 4'h0;
        next_sdaLow = 1'b0;
        next_sclLow = 1'b0;
      end else if (stopC) begin
        next_sState     = SLV_IDLE;
        next_sdaLow     = 1'b0;
        next_sclLow     = 1'b0;
        ev[EV_STOP_BIT] = 1'b1;
      end
    end
  end

  // Byte engine: storage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mState   <= MST_IDLE;
      sState   <= SLV_IDLE;
      step     <= 2'd0;
      phHigh   <= 1'b0;
      tmr      <= '0;
      bitCnt   <= 4'h0;
      shift    <= 8'h00;
      isAddr   <= 1'b0;
      isRead   <= 1'b0;
      ackOk    <= 1'b0;
      rxData   <= 8'h00;
      entValid <= 1'b0;
      entData  <= 8'h00;
      entCmd   <= 1'b0;
      entStop  <= 1'b0;
      sdaLow   <= 1'b0;
      sclLow   <= 1'b0;
      sclP     <= 1'b1;
      sdaP     <= 1'b1;
      sdaOe    <= 1'b0;
      sclOe    <= 1'b0;
    end else begin
      mState   <= next_mState;
      sState   <= next_sState;
      step     <= next_step;
      phHigh   <= next_phHigh;
      tmr      <= next_tmr;
      bitCnt   <= next_bitCnt;
      shift    <= next_shift;
      isAddr   <= next_isAddr;
      isRead   <= next_isRead;
      ackOk    <= next_ackOk;
      rxData   <= next_rxData;
      entValid <= next_entValid;
      entData  <= next_entData;
      entCmd   <= next_entCmd;
      entStop  <= next_entStop;
      sdaLow   <= next_sdaLow;
      sclLow   <= next_sclLow;
      sclP     <= next_sclP;
      sdaP     <= next_sdaP;
      sdaOe    <= next_sdaLow;
      sclOe    <= next_sclLow;
    end
  end
endmodule

// [verification/dcs_data_cmd_timing_asserts.sv]
// Concurrent checks on the register port and clock pin of the block
`timescale 1ns/1ps
module dcs_data_cmd_timing_asserts
  import dcs_pkg::*;
(
  // Clock, reset and register port
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  // Clock pin enable
  input wire logic        sclOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Shadow of enable bit and high count
  logic             en, next_en;
  logic [CNT_W-1:0] hi, next_hi;
  wire  [CNT_W-1:0] wv = regWrData[CNT_W-1:0];
  always_comb begin
    next_en = en;
    next_hi = hi;
    if (regWr && regAddr == ADDR_CTRL) next_en = regWrData[CTRL_EN_BIT];
    if (regWr && regAddr == ADDR_SHIGH && !en)
      next_hi = (wv < SHIGH_MIN) ? SHIGH_MIN : wv;
  end
  always_ff @(posedge sys_clk) begin
    en <= rstn ? next_en : 1'b0;
    hi <= rstn ? next_hi : SHIGH_RST;
  end
  sequence rdAt(logic [7:0] a);
    regRd && regAddr == a;
  endsequence
  rd_idle_zero_a: assert property (
    !regRd |=> regRdData == 32'h0) else $error("Idle read data set");
  data_resv_zero_a: assert property (
    rdAt(ADDR_DATA) |=> regRdData[31:8] == 24'h0) else $error("Data hi");
  cnt_resv_zero_a: assert property (
    rdAt(ADDR_SLOW) |=> regRdData[31:14] == 18'h0) else $error("Cnt hi");
  low_min_a: assert property (
    rdAt(ADDR_SLOW) |=> regRdData[13:0] >= SLOW_MIN) else $error("Low min");
  high_min_a: assert property (
    rdAt(ADDR_SHIGH) |=> regRdData[13:0] >= SHIGH_MIN) else $error("Hi min");
  high_track_a: assert property (
    rdAt(ADDR_SHIGH) |=> regRdData[13:0] == $past(hi)) else $error("Hi val");
  scl_low_len_a: assert property (
    $rose(sclOe) |-> sclOe[*8]) else $error("Clock low too short");
  scl_high_len_a: assert property (
    $fell(sclOe) |-> !sclOe[*6]) else $error("Clock high too short");
endmodule
bind dcs_data_cmd_timing dcs_data_cmd_timing_asserts i_chk (
  .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .sclOe(sclOe));

// [verification/dcs_bus_target.sv]
// Behavioural bus target that acknowledges bytes and answers reads
`timescale 1ns/1ps
module dcs_bus_target (
  // Wire levels
  input  wire logic  scl,
  input  wire logic  sda,
  // Data line pull and last byte seen
  output logic       sdaPull,
  output logic [7:0] lastByte
);
  logic [3:0] bitCnt = 4'hA;         // Bit slot since start
  logic [7:0] shift;                 // Bits seen on clock rise
  logic       addrPh, rdMode, nack;  // Address phase, read, nack seen
  localparam logic [7:0] RD_BYTE = 8'h3C; // Byte returned on reads
  initial sdaPull = 1'b0;
  // Start condition restarts the slot count
  always @(negedge sda) if (scl) begin
    bitCnt = 4'hF;
    addrPh = 1'b1;
    nack = 1'b0;
  end
  always @(posedge scl) begin
    shift = {shift[6:0], sda};
    if (bitCnt == 4'h8) nack = sda;
  end
  // Drive ack or read data after each falling clock
  always @(negedge scl) begin
    bitCnt = bitCnt + 4'h1;
    if (bitCnt == 4'h8) lastByte = shift;
    if (bitCnt == 4'h8 && addrPh) rdMode = shift[0];
    if (bitCnt == 4'h9) begin
      bitCnt = 4'h0;
      addrPh = 1'b0;
    end
    sdaPull = (bitCnt == 4'h8) ? !(rdMode && !addrPh) :
      (rdMode && !addrPh && !nack && bitCnt < 4'h8 &&
       !RD_BYTE[3'h7 - bitCnt[2:0]]);
  end
endmodule

// [verification/dcs_data_cmd_timing_test.sv]
// Self-checking bench for the data/command and timing block
`timescale 1ns/1ps
module dcs_data_cmd_timing_test
  import dcs_pkg::*;
;
  logic        sys_clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00, lastByte;
  logic [31:0] regWrData = 32'h0, regRdData, rdVal;
  logic        irq, sclOut, sclOe, sdaOut, sdaOe, sdaPull;
  int          error_cnt = 0, num_checks = 0;
  wire         scl = !sclOe;              // Pulled up unless driven
  wire         sda = !(sdaOe || sdaPull);
  always #25 sys_clk = !sys_clk;
  dcs_data_cmd_timing i_dcs_data_cmd_timing (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .sclIn(scl), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
  dcs_bus_target i_dcs_bus_target (
    .scl(scl), .sda(sda), .sdaPull(sdaPull), .lastByte(lastByte));
  // ==========================================
  // Shared tasks
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);  // Answer stands in this cycle
    rdVal = regRdData;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rdVal, exp);
  endtask
  // Poll raw status until an event bit sets, bounded
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    rdVal = 32'h0;
    while (rdVal[b] !== 1'b1 && n < 2000) begin
      rd(ADDR_STAT);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_setup();
    rc(ADDR_SHIGH, 32'h190);
    rc(ADDR_SLOW, 32'h1D6);
    rc(ADDR_DATA, 32'h0);
    wr(ADDR_SHIGH, 32'hFFFF_C002);
    wr(ADDR_SLOW, 32'h3);
    rc(ADDR_SHIGH, 32'h6);
    rc(ADDR_SLOW, 32'h8);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_SHIGH, 32'h100);
    wr(ADDR_SLOW, 32'h100);
    rc(ADDR_SHIGH, 32'h6);
    rc(ADDR_SLOW, 32'h8);
    rc(8'h3C, 32'h0);
  endtask
  task automatic t_write();
    wr(ADDR_MASK, 32'h250);
    wr(ADDR_DATA, 32'h0A5);            // No stop: clock held after
    wait_ev(EV_TXE_BIT);
    check({24'h0, lastByte}, 32'hA5);
    check(rdVal & 32'h200, 32'h0);
    check({31'h0, sclOe}, 32'h1);
    wr(ADDR_DATA, 32'h25A);            // Same direction continues
    wait_ev(EV_STOP_BIT);
    check(rdVal & 32'h250, 32'h210);
    check({24'h0, lastByte}, 32'h5A);
    check({31'h0, sclOe}, 32'h0);
    check({30'h0, sclOut, sdaOut}, 32'h0);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_MASK, 32'h0);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_STAT, 32'h250);
    wr(ADDR_MASK, 32'h250);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic t_read();
    wr(ADDR_DATA, 32'h300);
    wait_ev(EV_STOP_BIT);
    check(rdVal & 32'h254, 32'h214);
    rc(ADDR_DATA, 32'h3C);
    wr(ADDR_STAT, 32'h3FF);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_TARGET, 32'h855);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_DATA, 32'h300);
    wait_ev(EV_ABORT_BIT);
    check(rdVal & 32'h244, 32'h40);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_setup();
    t_write();
    t_read();
    finish_test();
  end
endmodule
